// ---- rtl/ubsd_decoder.sv ----
`include "ubsd_defs.svh"
// Summary of operation
// - Selected peripheral shown as a three-bit code on the encoded select outputs.
// - Bank select low picks decoder one, high picks decoder two.
// - Code 000 on writes 70-76h even; code 001 on 71-77h odd.
// - Code 010 for keyboard at 60h, 64h, plus 62h, 66h in wide variant.
// - Boot memory code 011 always for F segment and its high aliases.
// - E segment and aliases decode as boot memory only when enabled.
// - Extra boot region below 4 GB top decodes only when enabled.
// - Floppy 100, disk 101, disk alt 110; one primary/secondary bit.
// - Bank high: 001 at 0C00h, 010 for 0800h-08FFh.
// - Bank high: serial A 011, serial B 100, each at COM1 or COM2.
// - Bank high: printer 101 at one programmed range only.
// - Idle is 111 high; reserved codes never produced.
// - Lower byte transceiver run by active-low enable and direction.
// - Floppy change read drives inverted change input onto data bit 7.
// - Bit 7 driven only with floppy on, disk off; else transceiver follows disk.
// - Port 92h register drives alternate reset and address-20 gate.
// - Enable bit 5 and active coprocessor error raise interrupt 13.
// - Write to F0h clears interrupt 13 and holds ignore until error clears.
// - Ignore output asserted with coprocessor error inactive only in reset and for one clock after the error clears.
module ubsd_decoder
  import ubsd_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // Bus cycle
  input  wire logic [31:0]       addr_in,
  input  wire logic              io_cyc_in,
  input  wire logic              mem_cyc_in,
  input  wire logic              rd_in,
  input  wire logic              wr_in,
  input  wire logic              dma_cyc_in,
  input  wire logic [7:0]        wdata_in,
  // Configuration
  input  wire logic              kbd_wide_in,
  input  wire logic              bios_lower_en_in,
  input  wire logic              bios_ext_en_in,
  input  wire logic              fdc_en_in,
  input  wire logic              disk_en_in,
  input  wire logic              fdc_disk_sec_in,
  input  wire ubsd_pkg::ubsd_com_t serial_a_map_in,
  input  wire ubsd_pkg::ubsd_com_t serial_b_map_in,
  input  wire ubsd_pkg::ubsd_lpt_t printer_map_in,
  input  wire logic              clk_div_cfg_in,
  // Pins
  input  wire logic              disk_change_in,
  input  wire logic              fpu_error_n_in,
  // Encoded selects
  output logic                   enc_select_bit2_out,
  output logic                   enc_select_bit1_out,
  output logic                   enc_select_bit0_out,
  output logic                   decoder_bank_sel_n_out,
  // Transceiver and data bit 7
  output logic                   periph_xcvr_oe_n_out,
  output logic                   periph_xcvr_dir_out,
  output logic                   sys_data_bit7_out,
  output logic                   sys_data_bit7_oe_n_out,
  // Processor side
  output logic                   alt_addr20_gate_out,
  output logic                   alt_cpu_reset_out,
  output logic                   fpu_irq_line_out,
  output logic                   cpu_int_out,
  output logic                   ignore_fpu_err_n_out,
  output logic                   sys_mgmt_irq_n_out,
  output logic                   cpu_nmi_out,
  output logic                   cpu_stop_clock_n_out
);
  import ubsd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0]      code;
    logic            bank;
    logic            xcvr_oe_n;
    logic            xcvr_dir;
    logic            d7;
    logic            d7_oe_n;
    logic            a20;
    logic            rst;
    logic            fpu_irq_line;
    ubsd_fpu_state_t fst;
  } ubsd_state_t;

  ubsd_state_t st_reg;
  ubsd_state_t st_next;
  logic        fpu_err_lvl;
  logic        dchg_lvl;
  logic        fpu_err_act;

  ubsd_sync u_sync_fpu_error_n (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .async_in  (~fpu_error_n_in),
    .level_out (fpu_err_lvl)
  );

  ubsd_sync u_sync_dchg (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .async_in  (disk_change_in),
    .level_out (dchg_lvl)
  );

  assign fpu_err_act = fpu_err_lvl;

  ////////////////////////////////////////////////////////////////////////////////
  // Address match terms.
  logic [15:0] ioa;
  logic        io_any;
  logic        hit_rtc_a;
  logic        hit_rtc_d;
  logic        hit_kbd;
  logic        hit_bios;
  logic        hit_fdc;
  logic        hit_dsk0;
  logic        hit_dsk1;
  logic        hit_cpage;
  logic        hit_cram;
  logic        hit_sera;
  logic        hit_serb;
  logic        hit_lpt;
  logic        hit_dchg;
  logic        hit_p92w;
  logic        hit_fclr;
  logic [15:0] fbase;
  logic [15:0] dbase;
  logic [15:0] d1base;
  logic [15:0] seg;

  function automatic logic com_hit(input logic [15:0] a, input ubsd_com_t m);
    logic r;
    r = 1'b0;
    if (m == UBSD_COM_1) begin
      r = ((a & 16'hFFF8) == `UBSD_IO_COM1);
    end else if (m == UBSD_COM_2) begin
      r = ((a & 16'hFFF8) == `UBSD_IO_COM2);
    end
    return r;
  endfunction

  always_comb begin
    ioa       = addr_in[15:0];
    io_any    = io_cyc_in && (rd_in || wr_in) && (addr_in[31:16] == 16'h0000);
    seg       = addr_in[31:16];
    fbase     = fdc_disk_sec_in ? `UBSD_IO_FDC_SEC : `UBSD_IO_FDC_PRI;
    dbase     = fdc_disk_sec_in ? `UBSD_IO_DSK_SEC : `UBSD_IO_DSK_PRI;
    d1base    = fdc_disk_sec_in ? `UBSD_IO_DSK1_SEC : `UBSD_IO_DSK1_PRI;
    hit_rtc_a = io_any && wr_in && ((ioa & 16'hFFF8) == `UBSD_IO_RTC_BASE) && !ioa[0];
    hit_rtc_d = io_any && ((ioa & 16'hFFF8) == `UBSD_IO_RTC_BASE) && ioa[0];
    hit_kbd   = io_any && ((ioa == `UBSD_IO_KBD_A) || (ioa == `UBSD_IO_KBD_B) ||
                (kbd_wide_in && ((ioa == `UBSD_IO_KBD_C) || (ioa == `UBSD_IO_KBD_D))));
    // F segment always, E segment gated, extension gated
    hit_bios  = mem_cyc_in && (rd_in || wr_in) &&
                ((seg == `UBSD_BIOS_F_SEG) || (seg == `UBSD_BIOS_HI_F) ||
                 (seg == `UBSD_BIOS_LO_F) ||
                 (bios_lower_en_in && ((seg == `UBSD_BIOS_E_SEG) ||
                  (seg == `UBSD_BIOS_HI_E) || (seg == `UBSD_BIOS_LO_E))) ||
                 (bios_ext_en_in && (seg >= `UBSD_BIOS_EXT_LO) &&
                  (seg <= `UBSD_BIOS_EXT_HI)));
    // floppy and disk share the primary/secondary choice
    hit_dsk1  = io_any && disk_en_in && (ioa[15:1] == d1base[15:1]);
    hit_fdc   = io_any && fdc_en_in && (ioa[15:3] == fbase[15:3]);
    hit_dsk0  = io_any && disk_en_in && (ioa[15:3] == dbase[15:3]);
    hit_cpage = io_any && (ioa == `UBSD_IO_CFG_PAGE);
    hit_cram  = io_any && ((ioa & 16'hFF00) == `UBSD_IO_CFG_RAM);
    hit_sera  = io_any && com_hit(ioa, serial_a_map_in);
    hit_serb  = io_any && com_hit(ioa, serial_b_map_in);
    // one printer range at a time
    unique case (printer_map_in)
      UBSD_LPT_1:   hit_lpt = io_any && ((ioa & 16'hFFFC) == `UBSD_IO_LPT1);
      UBSD_LPT_2:   hit_lpt = io_any && ((ioa & 16'hFFF8) == `UBSD_IO_LPT2);
      UBSD_LPT_3:   hit_lpt = io_any && ((ioa & 16'hFFF8) == `UBSD_IO_LPT3);
      UBSD_LPT_OFF: hit_lpt = 1'b0;
    endcase
    hit_dchg  = io_any && rd_in && !dma_cyc_in &&
                (ioa == (fdc_disk_sec_in ? `UBSD_IO_DCHG_SEC : `UBSD_IO_DCHG_PRI));
    hit_p92w  = io_any && wr_in && (ioa == `UBSD_IO_PORT92);
    hit_fclr  = io_any && wr_in && (ioa == `UBSD_IO_FPU_CLR);
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    // idle code 111 with bank high
    st_next.code = 3'h7;
    st_next.bank = 1'b1;
    // bank low for decoder one, high for decoder two
    if (hit_rtc_a) begin
      st_next.code = 3'h0;
      st_next.bank = 1'b0;
    end else if (hit_rtc_d) begin
      st_next.code = 3'h1;
      st_next.bank = 1'b0;
    end else if (hit_kbd) begin
      st_next.code = 3'h2;
      st_next.bank = 1'b0;
    end else if (hit_bios) begin
      st_next.code = 3'h3;
      st_next.bank = 1'b0;
    end else if (hit_dsk1) begin
      st_next.code = 3'h6;
      st_next.bank = 1'b0;
    end else if (hit_fdc) begin
      st_next.code = 3'h4;
      st_next.bank = 1'b0;
    end else if (hit_dsk0) begin
      st_next.code = 3'h5;
      st_next.bank = 1'b0;
    end else if (hit_cpage) begin
      st_next.code = 3'h1;
    end else if (hit_cram) begin
      st_next.code = 3'h2;
    end else if (hit_sera) begin
      st_next.code = 3'h3;
    end else if (hit_serb) begin
      st_next.code = 3'h4;
    end else if (hit_lpt) begin
      st_next.code = 3'h5;
    end

    // transceiver enabled for any utility bus select except a floppy-only disk change read
    st_next.xcvr_oe_n = (st_next.code == 3'h7) && st_next.bank;
    st_next.xcvr_dir  = rd_in;
    st_next.d7_oe_n   = 1'b1;
    st_next.d7        = 1'b0;
    if (hit_dchg) begin
      // bit 7 only in floppy-only mode, otherwise disk decides
      // The disk-only case needs board logic to avoid a clash on 3F7h/377h.
      // Only the disk enable is consulted here, as the board gate sits outside.
      if (fdc_en_in && !disk_en_in) begin
        st_next.d7        = ~dchg_lvl;
        st_next.d7_oe_n   = 1'b0;
        st_next.xcvr_oe_n = 1'b1;
      end else begin
        st_next.xcvr_oe_n = !disk_en_in;
      end
    end

    if (hit_p92w) begin
      st_next.rst = wdata_in[`UBSD_P92_RST_BIT];
      st_next.a20 = wdata_in[`UBSD_P92_A20_BIT];
    end

    // raise interrupt on error in enabled mode
    // clear write ends interrupt and, with error active, starts ignore
    // ignore drops on the clock after error goes inactive
    unique case (st_reg.fst)
      UBSD_FPU_IDLE: begin
        if (hit_fclr && fpu_err_act) begin
          st_next.fpu_irq_line = 1'b0;
          st_next.fst   = UBSD_FPU_IGNORE;
        end else if (hit_fclr) begin
          st_next.fpu_irq_line = 1'b0;
        end else if (clk_div_cfg_in && fpu_err_act) begin
          st_next.fpu_irq_line = 1'b1;
        end
      end
      UBSD_FPU_IGNORE: begin
        st_next.fpu_irq_line = 1'b0;
        if (!fpu_err_act) begin
          st_next.fst = UBSD_FPU_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    // idle select with bank high, enables off, all other fields low in reset
    if (!rstn_in) begin
      st_reg <= '{code: 3'h7, bank: 1'b1, xcvr_oe_n: 1'b1, xcvr_dir: 1'b0, d7: 1'b0,
                  d7_oe_n: 1'b1, a20: 1'b0, rst: 1'b0, fpu_irq_line: 1'b0, fst: UBSD_FPU_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign enc_select_bit2_out    = st_reg.code[2];
  assign enc_select_bit1_out    = st_reg.code[1];
  assign enc_select_bit0_out    = st_reg.code[0];
  assign decoder_bank_sel_n_out = st_reg.bank;
  assign periph_xcvr_oe_n_out   = st_reg.xcvr_oe_n;
  assign periph_xcvr_dir_out    = st_reg.xcvr_dir;
  assign sys_data_bit7_out      = st_reg.d7;
  assign sys_data_bit7_oe_n_out = st_reg.d7_oe_n;
  assign alt_addr20_gate_out    = st_reg.a20;
  assign alt_cpu_reset_out      = st_reg.rst;
  assign fpu_irq_line_out       = st_reg.fpu_irq_line;
  assign cpu_int_out            = st_reg.fpu_irq_line;
  // Ignore is low-active but must read low in reset, so outside the ignore state it follows reset.
  assign ignore_fpu_err_n_out   = (st_reg.fst == UBSD_FPU_IGNORE) ? 1'b0 : rstn_in;
  // Management, NMI and stop-clock belong to logic outside this block.
  assign sys_mgmt_irq_n_out     = rstn_in;
  assign cpu_nmi_out            = 1'b0;
  assign cpu_stop_clock_n_out   = rstn_in;

  ////////////////////////////////////////////////////////////////////////////////
  a_idle_on_miss: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(io_cyc_in || mem_cyc_in) |=> (st_reg.code == 3'h7) && st_reg.bank)
    else $error("select not idle on miss");
  a_no_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !((st_reg.code == 3'h7 && !st_reg.bank) || (st_reg.bank && (st_reg.code == 3'h0 ||
      st_reg.code == 3'h6)))) else $error("reserved select code");
  a_bios_f_seg: assert property (@(posedge clk_in) disable iff (!rstn_in)
    mem_cyc_in && rd_in && addr_in[31:16] == 16'h000F |=>
      st_reg.code == 3'h3 && !st_reg.bank) else $error("boot F segment missed");
  a_bios_e_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
    mem_cyc_in && addr_in[31:16] == 16'h000E && !bios_lower_en_in |=>
      st_reg.code != 3'h3) else $error("E segment decoded while off");
  a_rtc_strobe: assert property (@(posedge clk_in) disable iff (!rstn_in)
    io_cyc_in && wr_in && addr_in == 32'h0000_0072 |=>
      st_reg.code == 3'h0 && !st_reg.bank) else $error("clock strobe missed");
  a_dchg_drive: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !st_reg.d7_oe_n |-> st_reg.xcvr_oe_n) else $error("bit 7 with transceiver on");
  a_ign_needs_err: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !ignore_fpu_err_n_out |->
      $past(fpu_err_act)) else $error("ignore without error");
  a_clr_to_ign: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hit_fclr && fpu_err_act |=> !ignore_fpu_err_n_out && !fpu_irq_line_out)
    else $error("clear write did not ignore");
  a_irq_raise: assert property (@(posedge clk_in) disable iff (!rstn_in)
    clk_div_cfg_in && fpu_err_act && !hit_fclr && st_reg.fst == UBSD_FPU_IDLE |=>
      fpu_irq_line_out && cpu_int_out) else $error("interrupt 13 not raised");
  a_port92_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hit_p92w |=> alt_addr20_gate_out == $past(wdata_in[1]) &&
      alt_cpu_reset_out == $past(wdata_in[0])) else $error("port 92h not stored");
endmodule // ubsd_decoder

// ---- rtl/ubsd_defs.svh ----
`ifndef UBSD_DEFS_SVH
`define UBSD_DEFS_SVH
`define UBSD_IO_RTC_BASE     16'h0070
`define UBSD_IO_KBD_A        16'h0060
`define UBSD_IO_KBD_B        16'h0064
`define UBSD_IO_KBD_C        16'h0062
`define UBSD_IO_KBD_D        16'h0066
`define UBSD_IO_FDC_PRI      16'h03F0
`define UBSD_IO_FDC_SEC      16'h0370
`define UBSD_IO_DSK_PRI      16'h01F0
`define UBSD_IO_DSK_SEC      16'h0170
`define UBSD_IO_DSK1_PRI     16'h03F6
`define UBSD_IO_DSK1_SEC     16'h0376
`define UBSD_IO_DCHG_PRI     16'h03F7
`define UBSD_IO_DCHG_SEC     16'h0377
`define UBSD_IO_CFG_PAGE     16'h0C00
`define UBSD_IO_CFG_RAM      16'h0800
`define UBSD_IO_COM1         16'h03F8
`define UBSD_IO_COM2         16'h02F8
`define UBSD_IO_LPT1         16'h03BC
`define UBSD_IO_LPT2         16'h0378
`define UBSD_IO_LPT3         16'h0278
`define UBSD_IO_PORT92       16'h0092
`define UBSD_IO_FPU_CLR      16'h00F0
`define UBSD_BIOS_F_SEG      16'h000F
`define UBSD_BIOS_E_SEG      16'h000E
`define UBSD_BIOS_HI_F       16'hFFFF
`define UBSD_BIOS_HI_E       16'hFFFE
`define UBSD_BIOS_LO_F       16'hFFEF
`define UBSD_BIOS_LO_E       16'hFFEE
`define UBSD_BIOS_EXT_LO     16'hFFF8
`define UBSD_BIOS_EXT_HI     16'hFFFD
`define UBSD_P92_RST_BIT     0
`define UBSD_P92_A20_BIT     1
`define UBSD_FPU_EN_BIT      5
`endif

// ---- rtl/ubsd_pkg.sv ----
package ubsd_pkg;
  typedef enum logic [1:0] {UBSD_LPT_1, UBSD_LPT_2, UBSD_LPT_3, UBSD_LPT_OFF} ubsd_lpt_t;
  typedef enum logic [1:0] {UBSD_COM_1, UBSD_COM_2, UBSD_COM_OFF} ubsd_com_t;
  typedef enum logic {UBSD_FPU_IDLE, UBSD_FPU_IGNORE} ubsd_fpu_state_t;
endpackage

// ---- rtl/ubsd_sync.sv ----
module ubsd_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Pin level
  input  wire logic async_in,
  output logic      level_out
);
  logic [2:0] stage_reg;
  logic       level_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      stage_reg <= {stage_reg[1:0], async_in};
      // A change counts only when the last two stages agree.
      if (stage_reg[1] == stage_reg[2]) begin
        level_reg <= stage_reg[2];
      end
    end
  end
  assign level_out = level_reg;
endmodule // ubsd_sync

// ---- dv/ubsd_partner.sv ----
module ubsd_partner (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Device side
  input  wire logic [2:0]  code_in,
  input  wire logic        bank_in,
  input  wire logic        xcvr_oe_n_in,
  input  wire logic        dchg_cyc_in,
  input  wire logic        disk_only_in,
  input  wire logic        ignore_n_in,
  // Board side
  output logic [15:0]      sel_n_out,
  output logic             xcvr_oe_n_out,
  output logic             ignore_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mask_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // two bank decoders
  always_comb sel_n_out = ~(16'h0001 << {bank_in, code_in});
  always_comb xcvr_oe_n_out = xcvr_oe_n_in | (disk_only_in & dchg_cyc_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Two stages, so an assertion that coincides with the reset edge cannot glitch through.
  // reset mask stages
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) mask_reg <= 2'h0;
    else mask_reg <= {mask_reg[0], 1'b1};
  end
  always_comb ignore_n_out = mask_reg[1] ? ignore_n_in : 1'b1;
endmodule // ubsd_partner

// ---- dv/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ubsd_pkg::*;
  logic clk = 0, rstn = 0, io = 0, mem = 0, rd = 0, wr = 0, kbd_wide = 0, bios_lo = 0;
  logic bios_ext = 0, fdc_en = 1, disk_en = 1, sec = 0, clk_div = 0, dchg = 0, fpu_error_n_n = 1;
  logic        dma = 0;
  logic [31:0] addr = 32'h0000_0000;
  logic [7:0]  wdata = 8'h00;
  ubsd_com_t   ser_a = UBSD_COM_1, ser_b = UBSD_COM_2;
  ubsd_lpt_t   prn = UBSD_LPT_1;
  logic b2, b1, b0, bank, oe_n, dir, d7, d7_oe_n, a20, arst, irq, cint, ign_n, smi_n, nmi, stp_n;
  logic [15:0] sel_n;
  logic        gate_oe_n, mask_ign_n;
  int          n_mismatch = 0, cmp_count = 0, cycles = 0;
  always #2 clk = ~clk;
  ubsd_decoder i_dut (.clk_in(clk), .rstn_in(rstn), .addr_in(addr), .io_cyc_in(io),
    .mem_cyc_in(mem), .rd_in(rd), .wr_in(wr), .dma_cyc_in(dma), .wdata_in(wdata),
    .kbd_wide_in(kbd_wide), .bios_lower_en_in(bios_lo), .bios_ext_en_in(bios_ext),
    .fdc_en_in(fdc_en), .disk_en_in(disk_en), .fdc_disk_sec_in(sec),
    .serial_a_map_in(ser_a), .serial_b_map_in(ser_b), .printer_map_in(prn),
    .clk_div_cfg_in(clk_div), .disk_change_in(dchg), .fpu_error_n_in(fpu_error_n_n),
    .enc_select_bit2_out(b2), .enc_select_bit1_out(b1), .enc_select_bit0_out(b0),
    .decoder_bank_sel_n_out(bank), .periph_xcvr_oe_n_out(oe_n), .periph_xcvr_dir_out(dir),
    .sys_data_bit7_out(d7), .sys_data_bit7_oe_n_out(d7_oe_n), .alt_addr20_gate_out(a20),
    .alt_cpu_reset_out(arst), .fpu_irq_line_out(irq), .cpu_int_out(cint),
    .ignore_fpu_err_n_out(ign_n), .sys_mgmt_irq_n_out(smi_n), .cpu_nmi_out(nmi),
    .cpu_stop_clock_n_out(stp_n));
  ubsd_partner i_partner (.clk_in(clk), .rstn_in(rstn), .code_in({b2, b1, b0}),
    .bank_in(bank), .xcvr_oe_n_in(oe_n),
    .dchg_cyc_in(io & rd & (addr == 32'h0000_03F7 || addr == 32'h0000_0377)),
    .disk_only_in(disk_en & ~fdc_en), .ignore_n_in(ign_n), .sel_n_out(sel_n),
    .xcvr_oe_n_out(gate_oe_n), .ignore_n_out(mask_ign_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The bus cycle is presented on a falling edge and held; outputs are read after the next rise.
  task automatic cyc(input logic c_io, c_mem, c_rd, c_wr, input logic [31:0] a);
    @(negedge clk);
    io = c_io;
    mem = c_mem;
    rd = c_rd;
    wr = c_wr;
    addr = a;
    @(posedge clk);
    #1;
  endtask
  // Expected value is {bank, code}.
  task automatic code_is(input logic [3:0] exp);
    chk({28'h0, bank, b2, b1, b0}, {28'h0, exp});
    chk({16'h0000, sel_n}, {16'h0000, ~(16'h0001 << exp)});
  endtask
  task automatic wait_sync;
    repeat (6) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_rtc_kbd;
    for (int i = 0; i < 4; i++) begin
      cyc(1, 0, 0, 1, 32'h0000_0070 + 2 * i);
      code_is(4'h0);
      cyc(1, 0, 1, 0, 32'h0000_0071 + 2 * i);
      code_is(4'h1);
    end
    cyc(1, 0, 1, 0, 32'h0000_0060);
    code_is(4'h2);
    cyc(1, 0, 0, 1, 32'h0000_0064);
    code_is(4'h2);
    cyc(1, 0, 1, 0, 32'h0000_0062);
    code_is(4'hF);
    @(negedge clk) kbd_wide = 1;
    cyc(1, 0, 1, 0, 32'h0000_0066);
    code_is(4'h2);
    $display("test rtc_kbd done");
  endtask
  task automatic t_bios;
    logic [31:0] fa [3] = '{32'h000F_0000, 32'hFFFF_FFFF, 32'hFFEF_8000};
    foreach (fa[i]) begin
      cyc(0, 1, 1, 0, fa[i]);
      code_is(4'h3);
    end
    cyc(0, 1, 1, 0, 32'h000E_0000);
    code_is(4'hF);
    @(negedge clk) bios_lo = 1;
    cyc(0, 1, 0, 1, 32'hFFFE_0000);
    code_is(4'h3);
    cyc(0, 1, 1, 0, 32'hFFF8_0000);
    code_is(4'hF);
    @(negedge clk) bios_ext = 1;
    cyc(0, 1, 1, 0, 32'hFFFD_FFFF);
    code_is(4'h3);
    $display("test bios done");
  endtask
  task automatic t_disk;
    for (int s = 0; s < 2; s++) begin
      @(negedge clk) sec = s[0];
      cyc(1, 0, 1, 0, s ? 32'h0000_0370 : 32'h0000_03F0);
      code_is(4'h4);
      cyc(1, 0, 0, 1, s ? 32'h0000_0177 : 32'h0000_01F7);
      code_is(4'h5);
      chk(dir, 0);
      cyc(1, 0, 1, 0, s ? 32'h0000_0376 : 32'h0000_03F6);
      code_is(4'h6);
      chk({oe_n, dir}, 2'b01);
    end
    @(negedge clk) sec = 0;
    $display("test disk done");
  endtask
  task automatic t_bank2;
    cyc(1, 0, 1, 0, 32'h0000_0C00);
    code_is(4'h9);
    cyc(1, 0, 0, 1, 32'h0000_08FF);
    code_is(4'hA);
    cyc(1, 0, 1, 0, 32'h0000_03F8);
    code_is(4'hB);
    cyc(1, 0, 1, 0, 32'h0000_02FF);
    code_is(4'hC);
    @(negedge clk) begin
      ser_a = UBSD_COM_2;
      ser_b = UBSD_COM_1;
    end
    cyc(1, 0, 1, 0, 32'h0000_02F8);
    code_is(4'hB);
    cyc(1, 0, 0, 1, 32'h0000_03FF);
    code_is(4'hC);
    cyc(1, 0, 1, 0, 32'h0000_03BC);
    code_is(4'hD);
    @(negedge clk) prn = UBSD_LPT_2;
    cyc(1, 0, 1, 0, 32'h0000_037F);
    code_is(4'hD);
    @(negedge clk) prn = UBSD_LPT_3;
    cyc(1, 0, 0, 1, 32'h0000_0278);
    code_is(4'hD);
    cyc(1, 0, 1, 0, 32'h0000_03BC);
    code_is(4'hF);
    @(negedge clk) begin
      ser_b = UBSD_COM_OFF;
      prn = UBSD_LPT_OFF;
    end
    cyc(1, 0, 1, 0, 32'h0000_03F8);
    code_is(4'hF);
    cyc(1, 0, 0, 1, 32'h0000_0278);
    code_is(4'hF);
    $display("test bank2 done");
  endtask
  task automatic t_idle;
    cyc(1, 0, 1, 0, 32'h0000_0300);
    code_is(4'hF);
    cyc(1, 0, 1, 0, 32'h0001_0071);
    code_is(4'hF);
    cyc(1, 0, 0, 0, 32'h0000_0071);
    code_is(4'hF);
    chk({oe_n, d7_oe_n}, 2'b11);
    $display("test idle done");
  endtask
  task automatic t_disk_change_in;
    @(negedge clk) begin
      disk_en = 0;
      dchg = 1;
    end
    wait_sync;
    cyc(1, 0, 1, 0, 32'h0000_03F7);
    chk({d7_oe_n, d7, oe_n}, 3'b001);
    code_is(4'h4);
    @(negedge clk) dma = 1;
    cyc(1, 0, 1, 0, 32'h0000_03F7);
    chk(d7_oe_n, 1);
    @(negedge clk) dma = 0;
    @(negedge clk) begin
      sec = 1;
      dchg = 0;
    end
    wait_sync;
    cyc(1, 0, 1, 0, 32'h0000_0377);
    chk({d7_oe_n, d7, oe_n}, 3'b011);
    @(negedge clk) disk_en = 1;
    cyc(1, 0, 1, 0, 32'h0000_0377);
    chk({d7_oe_n, oe_n}, 2'b10);
    @(negedge clk) fdc_en = 0;
    cyc(1, 0, 1, 0, 32'h0000_0377);
    chk({d7_oe_n, oe_n, gate_oe_n}, 3'b101);
    @(negedge clk) begin
      fdc_en = 1;
      sec = 0;
    end
    $display("test disk_change_in done");
  endtask
  task automatic t_fpu;
    @(negedge clk) fpu_error_n_n = 0;
    wait_sync;
    chk({irq, cint}, 2'b00);
    @(negedge clk) clk_div = 1;
    wait_sync;
    chk({irq, cint, ign_n}, 3'b111);
    cyc(1, 0, 0, 1, 32'h0000_00F0);
    cyc(0, 0, 0, 0, 32'h0000_0000);
    chk({irq, ign_n}, 2'b00);
    chk(mask_ign_n, 0);
    @(negedge clk) fpu_error_n_n = 1;
    wait_sync;
    chk(ign_n, 1);
    cyc(1, 0, 0, 1, 32'h0000_00F0);
    cyc(0, 0, 0, 0, 32'h0000_0000);
    chk({irq, ign_n}, 2'b01);
    $display("test fpu done");
  endtask
  task automatic t_p92_reset;
    @(negedge clk) wdata = 8'h03;
    cyc(1, 0, 0, 1, 32'h0000_0092);
    cyc(0, 0, 0, 0, 32'h0000_0000);
    chk({a20, arst}, 2'b11);
    @(negedge clk) rstn = 0;
    #1 chk({24'h0, a20, arst, irq, cint, nmi, ign_n, smi_n, stp_n}, 32'h0);
    chk(mask_ign_n, 1);
    code_is(4'hF);
    repeat (3) @(posedge clk);
    @(negedge clk) rstn = 1;
    @(posedge clk);
    #1 chk({a20, arst, smi_n, stp_n, ign_n}, 5'b00111);
    $display("test p92_reset done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) rstn = 1;
    t_rtc_kbd;
    t_bios;
    t_disk;
    t_bank2;
    t_idle;
    t_disk_change_in;
    t_fpu;
    t_p92_reset;
    finish_test;
  end
endmodule // testbench
